/* asp_pkg.sv */
package asp_pkg;
  // register word addresses (16-bit word space)
  localparam logic [15:0] ADDR_COMM_CONTROL = 16'h7050;
  localparam logic [15:0] ADDR_CONTROL_ONE = 16'h7051;
  localparam logic [15:0] ADDR_BAUD_HIGH_BYTE = 16'h7052;
  localparam logic [15:0] ADDR_BAUD_LOW_BYTE = 16'h7053;
  localparam logic [15:0] ADDR_CONTROL_TWO = 16'h7054;
  localparam logic [15:0] ADDR_RECEIVE_STATUS = 16'h7055;
  localparam logic [15:0] ADDR_RECEIVE_EMULATION_BUFFER = 16'h7056;
  localparam logic [15:0] ADDR_RECEIVE_BUFFER = 16'h7057;
  localparam logic [15:0] ADDR_TRANSMIT_BUFFER = 16'h7059;
  localparam logic [15:0] ADDR_FIFO_TRANSMIT = 16'h705A;
  localparam logic [15:0] ADDR_FIFO_RECEIVE = 16'h705B;
  localparam logic [15:0] ADDR_FIFO_CONTROL = 16'h705C;
  localparam logic [15:0] ADDR_PRIORITY_CONTROL = 16'h705F;

  // comm_control fields
  localparam int CC_STOP2 = 7;
  localparam int CC_PAR_ODD_N = 6;
  localparam int CC_PAR_EN = 5;
  localparam int CC_ADDR_MODE = 3;
  localparam int CC_LEN_LSB = 0;
  // control_one fields
  localparam int C1_RXERR_IE = 6;
  localparam int C1_SW_RESET_N = 5;
  localparam int C1_TXWAKE = 3;
  localparam int C1_SLEEP = 2;
  localparam int C1_TX_EN = 1;
  localparam int C1_RX_EN = 0;
  // control_two fields
  localparam int C2_TX_IE = 0;
  localparam int C2_RX_IE = 1;
  // fifo_transmit fields
  localparam int FT_FIFO_EN = 6;
  // fifo_control fields
  localparam int FC_ABD_FLAG = 7;
  localparam int FC_ABD_CLR = 6;
  localparam int FC_ABD_EN = 5;

  // reset values
  localparam logic [7:0] RST_COMM_CONTROL = 8'h07;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_FIFO_TRANSMIT = 8'h00;

  localparam int OVERSAMPLE = 8;
  localparam logic [3:0] ZERO_DIV_TICKS = 4'h1;
  localparam int BREAK_BITS = 10;
  localparam int FIFO_DEPTH = 16;
  localparam int BUF_DEPTH = 4;
  localparam int SYNC_STAGES = 3;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } asp_bus_req_t;

  typedef struct packed {
    logic break_det;
    logic frame_err;
    logic overrun;
    logic parity_err;
  } asp_rx_err_t;

  typedef enum logic [2:0] {
    ASP_IDLE = 3'b000,
    ASP_START = 3'b001,
    ASP_DATA = 3'b010,
    ASP_PARITY = 3'b011,
    ASP_STOP = 3'b100
  } asp_state_t;
endpackage : asp_pkg

/* asp_fifo.sv */
`timescale 1ns/1ps
module asp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [CW-1:0] cnt, next_cnt;
  logic push, pop;

  assign in_ready = (cnt != CW'(DEPTH));
  assign out_valid = (cnt != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign level = cnt;
  assign out_data = mem[rp];

  always_comb begin
    next_wp = wp;
    next_rp = rp;
    next_cnt = cnt;
    if (flush) begin
      next_wp = '0;
      next_rp = '0;
      next_cnt = '0;
    end else begin
      if (push) next_wp = (wp == AW'(DEPTH-1)) ? '0 : wp + AW'(1);
      if (pop) next_rp = (rp == AW'(DEPTH-1)) ? '0 : rp + AW'(1);
      if (push && !pop) next_cnt = cnt + CW'(1);
      else if (pop && !push) next_cnt = cnt - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !flush) mem[wp] <= in_data;
  end
endmodule : asp_fifo

/* asp_core.sv */
`timescale 1ns/1ps
// Operation
// [R1] bit rate is clock/((divisor+1)*8), or clock/16 when divisor zero
// [R2] divisor is 16 bits, split over high and low byte registers
// [R3] nrz coding, every frame starts with one start bit
// [R4] one to eight data bits per frame, both directions
// [R5] even, odd or no parity, generated and checked
// [R6] one or two stop bits sent per frame
// [R7] receiver flags break, parity, overrun and framing separately
// [R8] both directions double buffered, own enable and own interrupt
// [R9] transmitter and receiver run independently or together
// [R10] idle-line and address-bit multiprocessor wake-up modes
// [R11] transmit ready flag set while holding buffer can take a char
// [R12] transmitter empty only when shift register holds nothing
// [R13] receive ready flag set when a char waits to be read
// [R14] break detect flag set on a break on the receive line
// [R15] receive error flag is or of the four error flags
// [R16] separate tx and rx interrupt enables, break not separately gated
// [R17] 8-bit data in low byte, high byte reads zero, writes ignored
// [R18] processor uses only 16-bit accesses
// [R19] optional 16-level fifo mode through fifo registers
// [R20] auto-baud hardware measures and adopts incoming bit rate
// [R21] line idles high, data sent lsb first
// [R22] receiver samples near bit centre with oversampling clock
module asp_core #(
  parameter int TX_FIFO_DEPTH = asp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire asp_pkg::asp_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin,
  output logic tx_irq,
  output logic rx_irq
);
  // registers
  logic [7:0] comm_control, control_one, baud_high_byte, baud_low_byte;
  logic [7:0] control_two, fifo_transmit, fifo_control, priority_control;
  logic [7:0] rx_buf;
  logic rx_wake;
  logic rx_ready, tx_buffer_ready_flag, tx_empty;
  asp_pkg::asp_rx_err_t err;
  logic abd_flag;

  logic wr, rd;
  assign wr = bus_req.wr;
  assign rd = bus_req.rd;
  function automatic logic hit(input logic [15:0] a);
    hit = (bus_req.addr == a);
  endfunction : hit

  logic [15:0] bit_rate_divisor;
  assign bit_rate_divisor = {baud_high_byte, baud_low_byte}; // R2
  logic [3:0] len;
  assign len = {1'b0, comm_control[2:0]} + 4'h1; // R4
  logic par_en, par_odd, stop2, addr_mode, fifo_en;
  assign par_en = comm_control[asp_pkg::CC_PAR_EN];
  assign par_odd = !comm_control[asp_pkg::CC_PAR_ODD_N];
  assign stop2 = comm_control[asp_pkg::CC_STOP2];
  assign addr_mode = comm_control[asp_pkg::CC_ADDR_MODE];
  assign fifo_en = fifo_transmit[asp_pkg::FT_FIFO_EN];
  logic run;
  assign run = control_one[asp_pkg::C1_SW_RESET_N];

  // oversample tick: 8 per bit; divisor 0 gives 16 clocks per bit
  logic [15:0] tdiv, next_tdiv;
  logic tick;
  logic [15:0] tick_period;
  assign tick_period = (bit_rate_divisor == 16'h0000) ?
    16'h0001 : bit_rate_divisor; // R1
  assign tick = (tdiv == 16'h0000);
  always_comb begin
    next_tdiv = tick ? tick_period : tdiv - 16'h0001;
  end

  // receive pin synchroniser
  logic [2:0] rsync;
  logic rxd;
  always_ff @(posedge clk) begin
    if (sys_rst) rsync <= 3'b111;
    else rsync <= {rsync[1:0], serial_rx_pin};
  end
  always_ff @(posedge clk) begin
    if (sys_rst) rxd <= 1'b1;
    else if (rsync[2] == rsync[1]) rxd <= rsync[2];
  end

  // transmit fifo (16 deep in either mode; only the ready flag acts as a holding buffer outside fifo mode)
  logic [8:0] tf_in, tf_out;
  logic tf_wr, tf_in_ready, tf_valid, tf_pop;
  logic [$clog2(TX_FIFO_DEPTH+1)-1:0] tf_level;
  assign tf_wr = wr && hit(asp_pkg::ADDR_TRANSMIT_BUFFER);
  assign tf_in = {control_one[asp_pkg::C1_TXWAKE], bus_req.wdata[7:0]};
  asp_fifo #(.WIDTH(9), .DEPTH(TX_FIFO_DEPTH)) u_txq (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(!run),
    .in_data(tf_in),
    .in_valid(tf_wr),
    .in_ready(tf_in_ready),
    .out_data(tf_out),
    .out_valid(tf_valid),
    .out_ready(tf_pop),
    .level(tf_level)
  );
  // outside fifo mode the ready flag is set only while no char is held ahead of the shifter
  assign tx_buffer_ready_flag = fifo_en ? tf_in_ready :
    (tf_level == '0); // R11 R8

  // transmitter
  asp_pkg::asp_state_t ts, next_ts;
  logic [2:0] tph, next_tph;
  logic [3:0] tbit, next_tbit;
  logic [8:0] tsh, next_tsh;
  logic tpar, next_tpar, ttx, next_ttx;
  logic tx_go;
  assign tx_go = control_one[asp_pkg::C1_TX_EN] && run; // R9
  assign tf_pop = (ts == asp_pkg::ASP_IDLE) && tx_go && tf_valid && tick;
  assign tx_empty = (ts == asp_pkg::ASP_IDLE); // R12

  always_comb begin
    next_ts = ts;
    next_tph = tph;
    next_tbit = tbit;
    next_tsh = tsh;
    next_tpar = tpar;
    next_ttx = ttx;
    if (tick) begin
      next_tph = tph + 3'h1;
      case (ts)
        asp_pkg::ASP_IDLE: begin
          next_ttx = 1'b1; // R21
          if (tf_pop) begin
            next_tsh = tf_out;
            next_ttx = 1'b0; // R3
            next_tph = 3'h0;
            next_tpar = par_odd;
            next_ts = asp_pkg::ASP_START;
          end
        end
        asp_pkg::ASP_START: if (tph == 3'h7) begin
          next_ts = asp_pkg::ASP_DATA;
          next_tbit = 4'h0;
          next_ttx = tsh[0]; // R21
          next_tpar = tpar ^ tsh[0];
        end
        asp_pkg::ASP_DATA: if (tph == 3'h7) begin
          next_tbit = tbit + 4'h1;
          next_tsh = {1'b0, tsh[8:1]};
          if (tbit + 4'h1 < len) begin // R4
            next_ttx = tsh[1];
            next_tpar = tpar ^ tsh[1];
          end else if (addr_mode) begin
            next_ts = asp_pkg::ASP_PARITY;
            next_ttx = tsh[8 - len + 1]; // R10
          end else if (par_en) begin
            next_ts = asp_pkg::ASP_PARITY;
            next_ttx = tpar; // R5
            next_tbit = 4'h9;
          end else begin
            next_ts = asp_pkg::ASP_STOP;
            next_ttx = 1'b1;
            next_tbit = 4'h0;
          end
        end
        asp_pkg::ASP_PARITY: if (tph == 3'h7) begin
          if (addr_mode && par_en && tbit != 4'h9) begin
            next_ttx = tpar; // R5
            next_tbit = 4'h9;
          end else begin
            next_ts = asp_pkg::ASP_STOP;
            next_ttx = 1'b1;
            next_tbit = 4'h0;
          end
        end
        asp_pkg::ASP_STOP: if (tph == 3'h7) begin
          if (stop2 && tbit == 4'h0) next_tbit = 4'h1; // R6
          else next_ts = asp_pkg::ASP_IDLE;
        end
        default: next_ts = asp_pkg::ASP_IDLE;
      endcase
    end
    if (!run) begin
      next_ts = asp_pkg::ASP_IDLE;
      next_ttx = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ts <= asp_pkg::ASP_IDLE;
      tph <= 3'h0;
      tbit <= 4'h0;
      tsh <= 9'h000;
      tpar <= 1'b0;
      ttx <= 1'b1;
      tdiv <= 16'h0000;
    end else begin
      ts <= next_ts;
      tph <= next_tph;
      tbit <= next_tbit;
      tsh <= next_tsh;
      tpar <= next_tpar;
      ttx <= next_ttx;
      tdiv <= next_tdiv;
    end
  end
  assign serial_tx_pin = ttx;

  // receiver
  asp_pkg::asp_state_t rs, next_rs;
  logic [2:0] rph, next_rph;
  logic [3:0] rbit, next_rbit;
  logic [7:0] rsh, next_rsh;
  logic rpar, next_rpar, raddr, next_raddr;
  logic [7:0] next_rx_buf;
  logic next_rx_ready, next_rx_wake;
  asp_pkg::asp_rx_err_t next_err;
  logic [4:0] zcnt, next_zcnt;
  logic [5:0] idle_cnt, next_idle_cnt;
  logic rx_go, rd_buf, sleep;
  assign rx_go = control_one[asp_pkg::C1_RX_EN] && run; // R9
  assign rd_buf = rd && hit(asp_pkg::ADDR_RECEIVE_BUFFER);
  assign sleep = control_one[asp_pkg::C1_SLEEP];

  always_comb begin
    next_rs = rs;
    next_rph = rph;
    next_rbit = rbit;
    next_rsh = rsh;
    next_rpar = rpar;
    next_raddr = raddr;
    next_rx_buf = rx_buf;
    next_rx_ready = rx_ready && !rd_buf;
    next_rx_wake = rx_wake;
    next_err = err;
    next_zcnt = zcnt;
    next_idle_cnt = idle_cnt;
    if (tick && rx_go) begin
      next_rph = rph + 3'h1;
      next_idle_cnt = (rxd && idle_cnt != 6'h3F) ? idle_cnt + 6'h01 :
        (rxd ? idle_cnt : 6'h00);
      case (rs)
        asp_pkg::ASP_IDLE: if (!rxd) begin
          next_rs = asp_pkg::ASP_START;
          next_rph = 3'h1;
          next_rpar = par_odd;
          next_zcnt = 5'h00;
          // idle line mode: a frame after 10+ idle oversample ticks carries an address
          next_rx_wake = (idle_cnt >= 6'(asp_pkg::BREAK_BITS)); // R10
        end
        asp_pkg::ASP_START: if (rph == 3'h3) begin // R22
          if (rxd) next_rs = asp_pkg::ASP_IDLE;
          else begin
            next_rs = asp_pkg::ASP_DATA;
            next_rph = 3'h4;
            next_rbit = 4'h0;
          end
        end
        asp_pkg::ASP_DATA: if (rph == 3'h3) begin // R22
          next_rsh = {rxd, rsh[7:1]};
          next_rpar = rpar ^ rxd;
          next_rbit = rbit + 4'h1;
          if (!rxd) next_zcnt = zcnt + 5'h01;
          if (rbit + 4'h1 == len)
            next_rs = (addr_mode || par_en) ? asp_pkg::ASP_PARITY :
              asp_pkg::ASP_STOP;
        end
        asp_pkg::ASP_PARITY: if (rph == 3'h3) begin
          if (!rxd) next_zcnt = zcnt + 5'h01;
          if (addr_mode && rbit != 4'hF) begin
            next_raddr = rxd; // R10
            next_rbit = 4'hF;
            if (!par_en) next_rs = asp_pkg::ASP_STOP;
          end else begin
            next_rpar = rpar ^ rxd;
            next_rs = asp_pkg::ASP_STOP;
          end
        end
        asp_pkg::ASP_STOP: if (rph == 3'h3) begin
          next_rs = asp_pkg::ASP_IDLE;
          if (!rxd) begin
            next_err.frame_err = 1'b1; // R7
            if (zcnt + 5'h01 >= 5'(len) + 5'h01)
              next_err.break_det = 1'b1; // R14
          end
          if (par_en && rpar) next_err.parity_err = 1'b1; // R5 R7
          if (!sleep || (addr_mode ? raddr : next_rx_wake)) begin
            if (rx_ready && !rd_buf) next_err.overrun = 1'b1; // R7
            next_rx_buf = (rsh >> (4'h8 - len)); // R21
            next_rx_ready = 1'b1; // R13
          end
        end
        default: next_rs = asp_pkg::ASP_IDLE;
      endcase
    end
    if (!run) begin
      next_rs = asp_pkg::ASP_IDLE;
      next_rx_ready = 1'b0;
      next_err = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rs <= asp_pkg::ASP_IDLE;
      rph <= 3'h0;
      rbit <= 4'h0;
      rsh <= 8'h00;
      rpar <= 1'b0;
      raddr <= 1'b0;
      rx_buf <= 8'h00;
      rx_ready <= 1'b0;
      rx_wake <= 1'b0;
      err <= '0;
      zcnt <= 5'h00;
      idle_cnt <= 6'h00;
    end else begin
      rs <= next_rs;
      rph <= next_rph;
      rbit <= next_rbit;
      rsh <= next_rsh;
      rpar <= next_rpar;
      raddr <= next_raddr;
      rx_buf <= next_rx_buf;
      rx_ready <= next_rx_ready;
      rx_wake <= next_rx_wake;
      err <= next_err;
      zcnt <= next_zcnt;
      idle_cnt <= next_idle_cnt;
    end
  end

  // auto-baud: measure low pulse of start bit, adopt divisor
  logic abd_on, abd_busy, next_abd_busy, next_abd_flag;
  logic [18:0] abd_cnt, next_abd_cnt;
  logic [15:0] abd_div;
  assign abd_on = fifo_control[asp_pkg::FC_ABD_EN] && !abd_flag;
  assign abd_div = 16'(abd_cnt >> 3) - 16'h0001;
  always_comb begin
    next_abd_busy = abd_busy;
    next_abd_cnt = abd_cnt;
    next_abd_flag = abd_flag;
    if (abd_on) begin
      if (!rxd) begin
        next_abd_busy = 1'b1;
        next_abd_cnt = abd_cnt + 19'h00001;
      end else if (abd_busy) begin
        next_abd_busy = 1'b0;
        next_abd_flag = 1'b1; // R20
      end
    end else next_abd_cnt = 19'h00000;
    if (wr && hit(asp_pkg::ADDR_FIFO_CONTROL) &&
        bus_req.wdata[asp_pkg::FC_ABD_CLR] && !next_abd_flag)
      next_abd_flag = 1'b0;
    else if (wr && hit(asp_pkg::ADDR_FIFO_CONTROL) &&
        bus_req.wdata[asp_pkg::FC_ABD_CLR] && !(abd_on && abd_busy && rxd))
      next_abd_flag = 1'b0;
  end

  // register writes, low byte only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      comm_control <= asp_pkg::RST_COMM_CONTROL;
      control_one <= asp_pkg::RST_ZERO;
      baud_high_byte <= asp_pkg::RST_ZERO;
      baud_low_byte <= asp_pkg::RST_ZERO;
      control_two <= asp_pkg::RST_ZERO;
      fifo_transmit <= asp_pkg::RST_FIFO_TRANSMIT;
      fifo_control <= asp_pkg::RST_ZERO;
      priority_control <= asp_pkg::RST_ZERO;
      abd_busy <= 1'b0;
      abd_cnt <= 19'h00000;
      abd_flag <= 1'b0;
    end else begin
      abd_busy <= next_abd_busy;
      abd_cnt <= next_abd_cnt;
      abd_flag <= next_abd_flag;
      if (abd_on && abd_busy && rxd) begin
        baud_high_byte <= abd_div[15:8]; // R20
        baud_low_byte <= abd_div[7:0];
      end else if (wr) begin
        if (hit(asp_pkg::ADDR_BAUD_HIGH_BYTE))
          baud_high_byte <= bus_req.wdata[7:0]; // R17
        if (hit(asp_pkg::ADDR_BAUD_LOW_BYTE))
          baud_low_byte <= bus_req.wdata[7:0];
      end
      if (wr) begin
        if (hit(asp_pkg::ADDR_COMM_CONTROL))
          comm_control <= bus_req.wdata[7:0];
        if (hit(asp_pkg::ADDR_CONTROL_ONE))
          control_one <= bus_req.wdata[7:0];
        if (hit(asp_pkg::ADDR_CONTROL_TWO))
          control_two <= {6'h00, bus_req.wdata[1:0]};
        if (hit(asp_pkg::ADDR_FIFO_TRANSMIT))
          fifo_transmit <= bus_req.wdata[7:0];
        if (hit(asp_pkg::ADDR_FIFO_CONTROL))
          fifo_control <= {2'h0, bus_req.wdata[5:0]};
        if (hit(asp_pkg::ADDR_PRIORITY_CONTROL))
          priority_control <= bus_req.wdata[7:0];
      end
    end
  end

  logic rx_error;
  assign rx_error = |err; // R15

  // read mux, high byte always zero
  logic [7:0] rmux;
  always_comb begin
    rmux = 8'h00;
    case (bus_req.addr)
      asp_pkg::ADDR_COMM_CONTROL: rmux = comm_control;
      asp_pkg::ADDR_CONTROL_ONE: rmux = control_one;
      asp_pkg::ADDR_BAUD_HIGH_BYTE: rmux = baud_high_byte;
      asp_pkg::ADDR_BAUD_LOW_BYTE: rmux = baud_low_byte;
      asp_pkg::ADDR_CONTROL_TWO:
        rmux = {tx_buffer_ready_flag, tx_empty, 4'h0, control_two[1:0]};
      asp_pkg::ADDR_RECEIVE_STATUS:
        rmux = {rx_error, rx_ready, err.break_det, err.frame_err,
                err.overrun, err.parity_err, rx_wake, 1'b0};
      asp_pkg::ADDR_RECEIVE_EMULATION_BUFFER: rmux = rx_buf;
      asp_pkg::ADDR_RECEIVE_BUFFER: rmux = rx_buf;
      asp_pkg::ADDR_FIFO_TRANSMIT:
        rmux = {1'b0, fifo_transmit[6], 1'b0, 5'(tf_level)}; // R19
      asp_pkg::ADDR_FIFO_RECEIVE: rmux = {7'h00, rx_ready};
      asp_pkg::ADDR_FIFO_CONTROL: rmux = {abd_flag, 1'b0, fifo_control[5:0]};
      asp_pkg::ADDR_PRIORITY_CONTROL: rmux = priority_control;
      default: rmux = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) bus_rdata <= 16'h0000;
    else if (rd) bus_rdata <= {8'h00, rmux}; // R17
  end

  assign tx_irq = control_two[asp_pkg::C2_TX_IE] &&
    tx_buffer_ready_flag; // R16
  assign rx_irq = (control_two[asp_pkg::C2_RX_IE] && rx_ready) ||
    (control_one[asp_pkg::C1_RXERR_IE] && rx_error) ||
    err.break_det; // R16
endmodule : asp_core

/* asp_asserts.sv */
`timescale 1ns/1ps
module asp_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire asp_pkg::asp_bus_req_t bus_req,
  input wire logic [15:0] bus_rdata,
  input wire logic serial_rx_pin,
  input wire logic serial_tx_pin,
  input wire logic tx_irq,
  input wire logic rx_irq
);
  logic [7:0] cc, next_cc, lo, next_lo;
  logic tx_ie, next_tx_ie;
  logic [5:0] low_cnt, next_low_cnt;
  // shadow copies of the plain read-write fields
  always_comb begin
    next_cc = cc;
    next_lo = lo;
    next_tx_ie = tx_ie;
    if (bus_req.wr) begin
      case (bus_req.addr)
        asp_pkg::ADDR_COMM_CONTROL: next_cc = bus_req.wdata[7:0];
        asp_pkg::ADDR_BAUD_LOW_BYTE: next_lo = bus_req.wdata[7:0];
        asp_pkg::ADDR_CONTROL_TWO: next_tx_ie = bus_req.wdata[0];
        default: next_cc = cc;
      endcase
    end
    next_low_cnt = low_cnt;
    if (serial_tx_pin) begin
      next_low_cnt = 6'h00;
    end else if (low_cnt != 6'h3F) begin
      next_low_cnt = low_cnt + 6'h01;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cc <= asp_pkg::RST_COMM_CONTROL;
      lo <= 8'h00;
      tx_ie <= 1'b0;
      low_cnt <= 6'h00;
    end else begin
      cc <= next_cc;
      lo <= next_lo;
      tx_ie <= next_tx_ie;
      low_cnt <= next_low_cnt;
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  a_reset_idle: assert property (
    $past(sys_rst) |-> serial_tx_pin && !tx_irq && !rx_irq)
    else $error("outputs not idle after reset");
  a_high_lane_zero: assert property (
    bus_rdata[15:8] == 8'h00) else $error("read high byte not zero");
  a_rdata_holds: assert property (
    !$past(bus_req.rd) |-> $stable(bus_rdata))
    else $error("read data moved without a read");
  a_unmapped_zero: assert property (
    bus_req.rd && bus_req.addr == 16'h7058 |=> bus_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_min_bit_low: assert property (
    $rose(serial_tx_pin) |-> low_cnt >= 6'h10)
    else $error("low period shorter than one bit");
  a_tx_irq_mask: assert property (
    (!tx_ie) [*3] |-> !tx_irq) else $error("tx irq while disabled");
  a_ie_readback: assert property (
    bus_req.rd && bus_req.addr == asp_pkg::ADDR_CONTROL_TWO
    |=> bus_rdata[0] == $past(tx_ie)) else $error("tx enable readback");
  a_baud_readback: assert property (
    bus_req.rd && bus_req.addr == asp_pkg::ADDR_BAUD_LOW_BYTE
    |=> bus_rdata[7:0] == $past(lo)) else $error("divisor readback");
  a_format_readback: assert property (
    bus_req.rd && bus_req.addr == asp_pkg::ADDR_COMM_CONTROL
    |=> bus_rdata[7:0] == $past(cc)) else $error("format readback");
endmodule : asp_asserts
bind asp_core asp_asserts i_asp_asserts (.clk(clk), .sys_rst(sys_rst),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .serial_rx_pin(serial_rx_pin),
  .serial_tx_pin(serial_tx_pin), .tx_irq(tx_irq), .rx_irq(rx_irq));

/* asp_peer.sv */
`timescale 1ns/1ps
module asp_peer (
  input wire logic clk,
  input wire logic line_in,
  output logic line_out
);
  int bit_clks = 16;
  int nsamp = 10;
  logic [11:0] got_q[$];
  logic [11:0] shift;
  initial line_out = 1'b1;
  task automatic send_raw(input logic [11:0] pat, input int n);
    for (int i = 0; i < n; i++) begin
      line_out = pat[i];
      repeat (bit_clks) @(negedge clk);
    end
    line_out = 1'b1;
  endtask : send_raw
  // samples each bit at its centre, start bit first
  always begin
    @(negedge line_in);
    repeat (bit_clks / 2) @(posedge clk);
    shift = 12'h000;
    for (int i = 0; i < nsamp; i++) begin
      shift[i] = line_in;
      if (i < nsamp - 1) repeat (bit_clks) @(posedge clk);
    end
    got_q.push_back(shift);
  end
endmodule : asp_peer

/* asp_core_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e, m) \
  begin \
    checks++; \
    if ((g) !== (e)) begin \
      failures++; \
      $display("wrong value at %0t: %s", $time, m); \
    end \
  end
module asp_core_tb;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  asp_pkg::asp_bus_req_t bus_req = '0;
  logic [15:0] bus_rdata, rv;
  logic rx_line, tx_line, tx_irq, rx_irq;
  int failures = 0;
  int checks = 0;
  int cycles = 0;
  int n;
  logic [11:0] pat;
  logic [7:0] fmts [5] = '{8'h07, 8'h64, 8'hA6, 8'h00, 8'hE7};
  always #10 clk = ~clk;
  asp_core #(.TX_FIFO_DEPTH(asp_pkg::FIFO_DEPTH)) i_asp_core (.clk(clk),
    .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .serial_rx_pin(rx_line), .serial_tx_pin(tx_line), .tx_irq(tx_irq),
    .rx_irq(rx_irq));
  asp_peer i_asp_peer (.clk(clk), .line_in(tx_line), .line_out(rx_line));
  task automatic report_and_stop();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      report_and_stop();
    end
  end
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge clk);
    bus_req = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(negedge clk);
    bus_req.wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [15:0] a, output logic [15:0] d);
    @(negedge clk);
    bus_req = '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(negedge clk);
    bus_req.rd = 1'b0;
    d = bus_rdata;
  endtask : rd
  task automatic rchk(input logic [15:0] a, input logic [15:0] m,
      input logic [15:0] e);
    rd(a, rv);
    `CHK(rv & m, e, "register read")
  endtask : rchk
  // line levels in send order; c returns the bit count
  function automatic logic [11:0] frame(input logic [7:0] d,
      input logic [7:0] cc, output int c);
    logic p;
    frame = 12'hFFF;
    frame[0] = 1'b0;
    p = 1'b0;
    c = 1 + int'(cc[2:0]) + 1;
    for (int i = 0; i <= int'(cc[2:0]); i++) begin
      frame[1 + i] = d[i];
      p = p ^ d[i];
    end
    if (cc[5]) begin
      frame[c] = p ^ ~cc[6];
      c++;
    end
    c = c + (cc[7] ? 2 : 1);
  endfunction : frame
  task automatic tx_burst(input logic [7:0] d, input logic [7:0] cc,
      input int k);
    logic [11:0] e, g, m;
    int c;
    e = frame(d, cc, c);
    i_asp_peer.nsamp = c;
    m = (12'h001 << c) - 12'h001;
    for (int j = 0; j < k; j++) begin
      wr(asp_pkg::ADDR_TRANSMIT_BUFFER, {8'h00, 8'(d + j)});
    end
    for (int t = 0; t < 9000 && i_asp_peer.got_q.size() < k; t++) begin
      @(negedge clk);
    end
    for (int j = 0; j < k; j++) begin
      e = frame(8'(d + j), cc, c);
      g = 12'hFFF;
      if (i_asp_peer.got_q.size() > 0) g = i_asp_peer.got_q.pop_front();
      `CHK(g, e & m, "sent frame")
    end
  endtask : tx_burst
  task automatic rx_wait(input logic [7:0] m, input logic [7:0] e);
    rv = 16'h0000;
    for (int t = 0; t < 60 && (rv[7:0] & m) !== e; t++) begin
      rd(asp_pkg::ADDR_RECEIVE_STATUS, rv);
    end
    `CHK(rv[7:0] & m, e, "receive status")
  endtask : rx_wait
  task automatic err_case(input logic [11:0] p, input int k, input int r,
      input logic [7:0] m);
    repeat (r) i_asp_peer.send_raw(p, k);
    rx_wait(m, m);
    wr(asp_pkg::ADDR_CONTROL_ONE, 16'h0003);
    wr(asp_pkg::ADDR_CONTROL_ONE, 16'h0023);
  endtask : err_case
  initial begin
    repeat (3) @(negedge clk);
    sys_rst = 1'b0;
    rchk(asp_pkg::ADDR_COMM_CONTROL, 16'hFFFF, 16'h0007);
    rchk(asp_pkg::ADDR_BAUD_HIGH_BYTE, 16'hFFFF, 16'h0000);
    rchk(16'h7058, 16'hFFFF, 16'h0000);
    wr(asp_pkg::ADDR_BAUD_LOW_BYTE, 16'hA501);
    rchk(asp_pkg::ADDR_BAUD_LOW_BYTE, 16'hFFFF, 16'h0001);
    $display("test registers done");
    wr(asp_pkg::ADDR_CONTROL_ONE, 16'h0023);
    wr(asp_pkg::ADDR_CONTROL_TWO, 16'h0001);
    rchk(asp_pkg::ADDR_CONTROL_TWO, 16'h00C3, 16'h00C1);
    `CHK(tx_irq, 1'b1, "tx irq")
    fork
      tx_burst(8'h11, 8'h07, 1);
      begin
        repeat (6) @(negedge clk);
        rchk(asp_pkg::ADDR_CONTROL_TWO, 16'h0040, 16'h0000);
      end
    join
    foreach (fmts[i]) begin
      wr(asp_pkg::ADDR_COMM_CONTROL, {8'h00, fmts[i]});
      tx_burst(8'hB5, fmts[i], 1);
    end
    $display("test formats done");
    wr(asp_pkg::ADDR_COMM_CONTROL, 16'h0007);
    for (int d = 0; d < 4; d++) begin
      wr(asp_pkg::ADDR_BAUD_LOW_BYTE, 16'(3 - d));
      i_asp_peer.bit_clks = d == 3 ? 16 : (4 - d) * 8;
      tx_burst(8'h96, 8'h07, 1);
    end
    wr(asp_pkg::ADDR_FIFO_TRANSMIT, 16'h0040);
    tx_burst(8'h40, 8'h07, 6);
    wr(asp_pkg::ADDR_FIFO_TRANSMIT, 16'h0000);
    $display("test rates and queue done");
    wr(asp_pkg::ADDR_CONTROL_TWO, 16'h0002);
    pat = frame(8'h3C, 8'h07, n);
    fork
      i_asp_peer.send_raw(pat, n);
      tx_burst(8'hC3, 8'h07, 1);
    join
    rx_wait(8'h40, 8'h40);
    `CHK({rx_irq, tx_irq}, 2'b10, "irq levels")
    rchk(asp_pkg::ADDR_RECEIVE_BUFFER, 16'hFFFF, 16'h003C);
    rchk(asp_pkg::ADDR_RECEIVE_STATUS, 16'h0040, 16'h0000);
    `CHK(rx_irq, 1'b0, "rx irq")
    $display("test receive done");
    err_case(pat, n, 2, 8'h88);
    wr(asp_pkg::ADDR_COMM_CONTROL, 16'h0067);
    pat = frame(8'h5A, 8'h67, n);
    pat[9] = ~pat[9];
    err_case(pat, n, 1, 8'h84);
    wr(asp_pkg::ADDR_COMM_CONTROL, 16'h0007);
    err_case(12'h000, 12, 1, 8'hB0);
    $display("test errors done");
    wr(asp_pkg::ADDR_FIFO_CONTROL, 16'h0020);
    i_asp_peer.bit_clks = 24;
    i_asp_peer.send_raw(12'hFFE, 2);
    rchk(asp_pkg::ADDR_FIFO_CONTROL, 16'h0080, 16'h0080);
    tx_burst(8'h5A, 8'h07, 1);
    $display("test auto rate done");
    report_and_stop();
  end
endmodule : asp_core_tb
